//--- sam_defs.svh
// Constants for the shift-and-add multiply step datapath.
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SAM_WORD_W 48
`define SAM_PAIR_W 96
`define SAM_CNT_W 6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAM_WORD_MSB 47
`define SAM_PAIR_MSB 95

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SAM_WORD_RST 48'h0000_0000_0000
`define SAM_CNT_RST 6'h00
`define SAM_CNT_MAX 6'h3F
`define SAM_FULL_STEPS 6'h30

`endif

//--- sam_pkg.sv
// Types shared by the multiply step datapath modules.
package sam_pkg;
`include "sam_defs.svh"

	typedef logic [`SAM_WORD_W-1:0] sam_word_t;
	typedef logic [`SAM_PAIR_W-1:0] sam_pair_t;
	typedef logic [`SAM_CNT_W-1:0] sam_cnt_t;

	// Whole state of the datapath top.
	typedef struct packed {
		sam_word_t acc_hi;
		sam_word_t acc_lo;
		sam_word_t mcand;
		logic sign;
		logic zero;
		sam_cnt_t steps;
		logic step_done;
	} sam_state_t;
endpackage

//--- sam_step_if.sv
// Carrier between the datapath top and its one-step arithmetic unit.
interface sam_step_if;
	import sam_pkg::*;
	sam_word_t hi;
	sam_word_t lo;
	sam_word_t mcand;
	sam_word_t hi_nxt;
	sam_word_t lo_nxt;

	// Arithmetic side computes the next pair from the present one.
	modport alu (
		input hi,
		input lo,
		input mcand,
		output hi_nxt,
		output lo_nxt
	);

	// Top side presents the registers and takes the next pair.
	modport core (
		output hi,
		output lo,
		output mcand,
		input hi_nxt,
		input lo_nxt
	);
endinterface

//--- sam_step_alu.sv
// One unsigned shift-and-add step on the joined accumulator pair.
`include "sam_defs.svh"
module sam_step_alu
	import sam_pkg::*;
(
	// Register values in, next pair out.
	sam_step_if.alu step
);
	logic [`SAM_WORD_W:0] sum;

	// Add the multiplicand when the low word's bit 0 is set, then shift the pair right.
	always_comb begin
		sum = {1'b0, step.hi};
		if (step.lo[0]) begin
			sum = {1'b0, step.hi} + {1'b0, step.mcand};
		end
		step.hi_nxt = {1'b0, sum[`SAM_WORD_MSB:1]};
		step.lo_nxt = {sum[0], step.lo[`SAM_WORD_MSB:1]};
	end
endmodule

//--- sam_mult_top.sv
// Datapath top for the single-step unsigned multiply instruction.
`include "sam_defs.svh"
module sam_mult_top
	import sam_pkg::*;
(
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Register loads from the sequencer.
	input wire logic i_load_hi,
	input wire logic i_load_lo,
	input wire logic i_load_mcand,
	input wire logic i_clear_hi,
	input wire sam_word_t i_load_data,
	// Multiply step issue.
	input wire logic i_step,
	// Register and flag view.
	output sam_word_t o_acc_hi,
	output sam_word_t o_acc_lo,
	output sam_word_t o_mcand,
	output sam_pair_t o_joined_accumulator_pair,
	output logic o_sign,
	output logic o_zero,
	output sam_cnt_t o_step_count,
	output logic o_step_done,
	output logic o_full_product
);
	// ----------------------------------------------------------------
	// State and step unit
	// ----------------------------------------------------------------
	sam_state_t state_r;
	sam_state_t state_nxt;
	sam_pair_t pair_nxt;
	sam_step_if step_bus ();

	// Present the registers to the step unit.
	assign step_bus.hi = state_r.acc_hi;
	assign step_bus.lo = state_r.acc_lo;
	assign step_bus.mcand = state_r.mcand;

	sam_step_alu u_alu (
		.step(step_bus.alu)
	);

	// Joined result of the step, high word on top.
	assign pair_nxt = {step_bus.hi_nxt, step_bus.lo_nxt};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// A step wins over loads in the same cycle, which are then dropped.
	always_comb begin
		state_nxt = state_r;
		state_nxt.step_done = 1'b0;
		if (i_step) begin
			// Exactly one step per issue; the pair takes the unsigned result.
			state_nxt.acc_hi = step_bus.hi_nxt;
			state_nxt.acc_lo = step_bus.lo_nxt;
			// Flags come from the joined result.
			state_nxt.sign = pair_nxt[`SAM_PAIR_MSB];
			state_nxt.zero = (pair_nxt == '0);
			state_nxt.step_done = 1'b1;
			// Count steps since the last clear, holding at the top.
			if (state_r.steps != `SAM_CNT_MAX) begin
				state_nxt.steps = state_r.steps + `SAM_CNT_W'(1);
			end
		end else begin
			if (i_clear_hi) begin
				// Clearing the high word starts a new sequence.
				state_nxt.acc_hi = `SAM_WORD_RST;
				state_nxt.steps = `SAM_CNT_RST;
			end else if (i_load_hi) begin
				state_nxt.acc_hi = i_load_data;
			end
			if (i_load_lo) begin
				state_nxt.acc_lo = i_load_data;
			end
			if (i_load_mcand) begin
				state_nxt.mcand = i_load_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// All datapath state in one register.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r.acc_hi <= `SAM_WORD_RST;
			state_r.acc_lo <= `SAM_WORD_RST;
			state_r.mcand <= `SAM_WORD_RST;
			state_r.sign <= 1'b0;
			state_r.zero <= 1'b1;
			state_r.steps <= `SAM_CNT_RST;
			state_r.step_done <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Every output comes from the state register; o_full_product is a compare on the step count.
	assign o_acc_hi = state_r.acc_hi;
	assign o_acc_lo = state_r.acc_lo;
	assign o_mcand = state_r.mcand;
	assign o_joined_accumulator_pair = {state_r.acc_hi, state_r.acc_lo};
	assign o_sign = state_r.sign;
	assign o_zero = state_r.zero;
	assign o_step_count = state_r.steps;
	assign o_step_done = state_r.step_done;
	assign o_full_product = (state_r.steps >= `SAM_FULL_STEPS);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	// Conditional sum of one step; the carry out of the top bit is dropped.
	function automatic sam_word_t step_sum(input sam_word_t hi, input sam_word_t lo,
		input sam_word_t mc);
		sam_word_t sum;
		sum = hi;
		if (lo[0]) begin
			sum = hi + mc;
		end
		return sum;
	endfunction

	// A step issue, and a step that follows another directly.
	sequence s_step;
		i_step;
	endsequence

	sequence s_two_steps;
		i_step ##1 i_step;
	endsequence

	// The high word's top bit is zero after every step.
	a_hi_top_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> !o_acc_hi[`SAM_WORD_MSB])
		else $error("high word bit 47 not zero after step");

	// High word is the halved conditional sum; a lost carry never reaches bit 47.
	a_hi_sum_shift: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_acc_hi ==
			(step_sum($past(o_acc_hi), $past(o_acc_lo), $past(o_mcand)) >> 1))
		else $error("high word not the halved conditional sum");

	// Low word shifts right by one.
	a_lo_shift: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_acc_lo[`SAM_WORD_MSB-1:0] == $past(o_acc_lo[`SAM_WORD_MSB:1]))
		else $error("low word did not shift right");

	// Low word's new top bit is the sum's least bit.
	a_lo_top_bit: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_acc_lo[`SAM_WORD_MSB] ==
			($past(o_acc_hi[0]) ^ ($past(o_acc_lo[0]) & $past(o_mcand[0]))))
		else $error("low word bit 47 not the sum bit");

	// The multiplicand holds across two steps in a row.
	a_mcand_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_two_steps |=> o_mcand == $past(o_mcand, 2))
		else $error("multiplicand changed by a step");

	// Zero flag follows the joined result.
	a_zero_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_zero == (o_joined_accumulator_pair == '0))
		else $error("zero flag does not match result");

	// Sign flag follows the top bit of the joined result.
	a_sign_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_sign == o_joined_accumulator_pair[`SAM_PAIR_MSB])
		else $error("sign flag does not match result");

	// Each issue below the top value adds exactly one to the step count.
	a_step_count: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step and (o_step_count != `SAM_CNT_MAX) |=> o_step_count == $past(o_step_count) + 1)
		else $error("step count not advanced by one");

	// Without an issue no step is reported and the pair only moves by a load or a clear.
	a_no_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!i_step && !i_load_hi && !i_load_lo && !i_clear_hi |=>
			!o_step_done && $stable(o_joined_accumulator_pair))
		else $error("pair changed without an issue");

	// A clear empties the high word and restarts the count.
	a_clear_hi: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		i_clear_hi && !i_step |=> o_acc_hi == '0 && o_step_count == '0)
		else $error("clear did not empty high word");

	// Every issue shows the done flag in the following cycle.
	a_step_done: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> o_step_done)
		else $error("no done pulse after a step");

	// A step never alters the multiplicand, even when a load comes with it.
	a_step_mcand: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step |=> $stable(o_mcand))
		else $error("multiplicand changed in a step cycle");

	// The step count holds at its top value.
	a_count_top: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		s_step and (o_step_count == `SAM_CNT_MAX) |=> o_step_count == `SAM_CNT_MAX)
		else $error("step count wrapped past its top");

	// Loads and clears leave both flags alone.
	a_flags_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!i_step |=> $stable(o_sign) && $stable(o_zero))
		else $error("flag changed without a step");
endmodule

//--- sam_seq_model.sv
// Sequencer model that issues loads and multiply steps to the datapath.
module sam_seq_model
	import sam_pkg::*;
(
	// Clock.
	input wire logic i_mclk,
	// Requests to the datapath.
	output logic o_load_hi,
	output logic o_load_lo,
	output logic o_load_mcand,
	output logic o_clear_hi,
	output sam_word_t o_load_data,
	output logic o_step
);
	timeunit 1ns;
	timeprecision 1ps;

	// Every request line idles low from time zero.
	initial begin
		{o_load_hi, o_load_lo, o_load_mcand, o_clear_hi, o_step} = 5'h00;
		o_load_data = 48'h0000_0000_0000;
	end

	// One-cycle request; released data flips so a stale word is never read back.
	task automatic cmd(input logic [4:0] k, input sam_word_t d);
		@(negedge i_mclk);
		{o_load_hi, o_load_lo, o_load_mcand, o_clear_hi, o_step} = k;
		o_load_data = d;
		@(negedge i_mclk);
		{o_load_hi, o_load_lo, o_load_mcand, o_clear_hi, o_step} = 5'h00;
		o_load_data = ~d;
	endtask

	// Back-to-back steps, one pulse cycle for each step wanted.
	task automatic steps(input sam_cnt_t n);
		@(negedge i_mclk);
		o_step = 1'b1;
		repeat (n) @(negedge i_mclk);
		o_step = 1'b0;
	endtask
endmodule

//--- shift_add_multiply_step_test.sv
// Self-checking bench for the shift-and-add multiply step datapath.
module shift_add_multiply_step_test
	import sam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Row of one multiply sequence and the pair it must leave.
	typedef struct packed {
		sam_word_t hi0;
		sam_word_t m;
		sam_word_t r;
		sam_cnt_t n;
		sam_pair_t pair;
	} sam_row_t;

	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic ld_hi, ld_lo, ld_mc, clr_hi, step;
	sam_word_t ld_data, acc_hi, acc_lo, mcand;
	sam_pair_t pair;
	logic sign, zero, done, full;
	sam_cnt_t count;
	sam_cnt_t exp_cnt;
	int fail_count = 0;
	int samples_checked = 0;
	sam_row_t rows [6] = '{
		'{48'h0, 48'h3, 48'h5, 6'h30, 96'h0000_0000_0000_0000_0000_000F},
		'{48'h0, 48'hFFFF_FFFF_FFFF, 48'h1, 6'h30, 96'h0000_0000_0000_FFFF_FFFF_FFFF},
		'{48'h0, 48'h5, 48'h7, 6'h04, 96'h0000_0000_0002_3000_0000_0000},
		'{48'hFFFF_FFFF_FFFF, 48'h1, 48'hFFFF_FFFF_FFFF, 6'h01, 96'h7FFF_FFFF_FFFF_0000_0000_0000},
		'{48'h6, 48'h2, 48'h9, 6'h01, 96'h0000_0000_0003_0000_0000_0001},
		'{48'h0, 48'h0, 48'h5, 6'h30, 96'h0}
	};

	// Clock at 250 MHz.
	always #2 i_mclk = ~i_mclk;

	sam_seq_model i_seq (.i_mclk(i_mclk), .o_load_hi(ld_hi), .o_load_lo(ld_lo),
		.o_load_mcand(ld_mc), .o_clear_hi(clr_hi), .o_load_data(ld_data), .o_step(step));

	sam_mult_top i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_load_hi(ld_hi),
		.i_load_lo(ld_lo), .i_load_mcand(ld_mc), .i_clear_hi(clr_hi), .i_load_data(ld_data),
		.i_step(step), .o_acc_hi(acc_hi), .o_acc_lo(acc_lo), .o_mcand(mcand),
		.o_joined_accumulator_pair(pair), .o_sign(sign), .o_zero(zero),
		.o_step_count(count), .o_step_done(done), .o_full_product(full));

	// Compares a word or pair value.
	task automatic chk_w(input sam_pair_t got, input sam_pair_t exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask

	// Compares a flag.
	task automatic chk_b(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge i_mclk);
		fail_count++;
		final_report();
	end

	// Main sequence: reset, table of products, then the awkward cases.
	initial begin
		repeat (5) @(negedge i_mclk);
		i_resetn = 1'b1;
		chk_w(pair, 96'h0);
		chk_b(zero, 1'b1);
		chk_b(done, 1'b0);
		chk_w(count, 6'h00);
		chk_b(full, 1'b0);
		exp_cnt = 6'h00;
		foreach (rows[k]) begin
			if (rows[k].hi0 === 48'h0) begin
				i_seq.cmd(5'h02, 48'h0);
				exp_cnt = 6'h00;
			end else begin
				i_seq.cmd(5'h10, rows[k].hi0);
			end
			i_seq.cmd(5'h08, rows[k].m);
			i_seq.cmd(5'h04, rows[k].r);
			i_seq.steps(rows[k].n);
			exp_cnt = exp_cnt + rows[k].n;
			chk_w(pair, rows[k].pair);
			chk_w(acc_hi, rows[k].pair[95:48]);
			chk_w(acc_lo, rows[k].pair[47:0]);
			chk_w(mcand, rows[k].r);
			chk_b(sign, rows[k].pair[95]);
			chk_b(zero, rows[k].pair === 96'h0);
			chk_b(full, rows[k].n == 6'h30);
			chk_w(count, exp_cnt);
		end
		// Loads in a step cycle are dropped while the single step is taken.
		i_seq.cmd(5'h02, 48'h0);
		i_seq.cmd(5'h08, 48'h2);
		i_seq.cmd(5'h0D, 48'h3);
		chk_w(acc_lo, 48'h1);
		chk_w(mcand, 48'h5);
		chk_w(count, 6'h01);
		chk_b(done, 1'b1);
		@(negedge i_mclk);
		chk_b(done, 1'b0);
		// A clear beats a high-word load in the same cycle and restarts the count.
		i_seq.cmd(5'h10, 48'hA);
		i_seq.cmd(5'h12, 48'h9);
		chk_w(acc_hi, 48'h0);
		chk_w(count, 6'h00);
		// The count holds at its top value once 63 steps have passed.
		i_seq.steps(6'h3F);
		i_seq.cmd(5'h01, 48'h0);
		chk_w(count, 6'h3F);
		chk_b(full, 1'b1);
		// Reset in mid-run clears the datapath at once.
		i_seq.cmd(5'h08, 48'h7);
		i_resetn = 1'b0;
		#1;
		chk_w(acc_lo, 48'h0);
		chk_w(mcand, 48'h0);
		chk_b(zero, 1'b1);
		// After the release the datapath starts clean and multiplies again.
		repeat (2) @(negedge i_mclk);
		i_resetn = 1'b1;
		chk_w(count, 6'h00);
		chk_b(full, 1'b0);
		i_seq.cmd(5'h02, 48'h0);
		i_seq.cmd(5'h08, rows[2].m);
		i_seq.cmd(5'h04, rows[2].r);
		i_seq.steps(rows[2].n);
		chk_w(pair, rows[2].pair);
		chk_w(count, 6'h04);
		final_report();
	end
endmodule
